// [hw/fsp_pkg.sv]
// package: register map, field layout, codes and carriers for the flash self-programming protect block
package fsp_pkg;

  // =====================================================================
  // register addresses in the peripheral space
  localparam logic [15:0] FSP_ADDR_PROTECT_KEY = 16'hFFA0;
  localparam logic [15:0] FSP_ADDR_ERROR_STATUS = 16'hFFA1;
  localparam logic [15:0] FSP_ADDR_MODE_CONTROL = 16'hFFA2;
  localparam logic [15:0] FSP_ADDR_COMMAND_SELECT = 16'hFFA3;

  // =====================================================================
  // field positions and values
  localparam logic [7:0] FSP_KEY_VALUE = 8'hA5;
  localparam int FSP_BIT_SEQ_ERR = 0;
  localparam int FSP_BIT_VERIFY_ERR = 1;
  localparam int FSP_BIT_PROTECT_ERR = 2;
  localparam int FSP_BIT_SELF_PROG = 0;
  localparam int FSP_PROT_LSB = 2;
  localparam int FSP_PROT_WIDTH = 5;
  localparam int FSP_CMD_WIDTH = 3;

  // =====================================================================
  // values after reset
  localparam logic [7:0] FSP_RST_STATUS = 8'h00;
  localparam logic [2:0] FSP_RST_COMMAND = 3'h0;
  localparam logic FSP_RST_MODE = 1'b0;
  localparam logic [7:0] FSP_RST_RDATA = 8'h00;

  // =====================================================================
  // command codes
  localparam logic [2:0] FSP_CMD_VERIFY1 = 3'h1;
  localparam logic [2:0] FSP_CMD_VERIFY2 = 3'h2;
  localparam logic [2:0] FSP_CMD_BLOCK_ERASE = 3'h3;
  localparam logic [2:0] FSP_CMD_BLANK_CHECK = 3'h4;
  localparam logic [2:0] FSP_CMD_BYTE_WRITE = 3'h5;

  // =====================================================================
  // carriers
  typedef struct packed {
    logic store;
    logic load;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fsp_bus_s;

  typedef struct packed {
    logic protect_error;
    logic verify_error;
    logic sequence_error;
  } fsp_flags_s;

  typedef struct packed {
    logic done;
    logic verify_fail;
    logic overwrite_zero;
  } fsp_array_rsp_s;

endpackage

// [hw/fsp_protect.sv]
// top module: keyed mode unlock, error status flags, command select and command launch
`timescale 1ns/10ps

module fsp_protect
  import fsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire fsp_bus_s bus,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire logic [FSP_PROT_WIDTH-1:0] protect_setting,
  input wire logic block_protected,
  input wire logic exec_request,
  input wire fsp_array_rsp_s array_rsp,
  output logic array_start,
  output logic [FSP_CMD_WIDTH-1:0] array_cmd,
  output logic exec_busy,
  output logic exec_done,
  output logic self_program_select,
  output logic interrupt_hold
);

  // =====================================================================
  // decode of the current peripheral store
  logic st_key;
  logic st_mode;
  logic st_status;
  logic st_cmd;
  logic key_good;

  assign st_key = bus.store && (bus.addr == FSP_ADDR_PROTECT_KEY);
  assign st_mode = bus.store && (bus.addr == FSP_ADDR_MODE_CONTROL);
  assign st_status = bus.store && (bus.addr == FSP_ADDR_ERROR_STATUS);
  assign st_cmd = bus.store && (bus.addr == FSP_ADDR_COMMAND_SELECT);
  assign key_good = bus.wdata == FSP_KEY_VALUE;

  // =====================================================================
  // unlock sequence
  typedef enum logic [1:0] {
    FSP_SEQ_IDLE,
    FSP_SEQ_KEYED,
    FSP_SEQ_FIRST,
    FSP_SEQ_INVERTED
  } fsp_seq_e;

  fsp_seq_e seq_state;
  fsp_seq_e next_seq_state;
  logic [7:0] first_value;
  logic [7:0] next_first_value;
  logic mode_bit;
  logic next_mode_bit;
  logic seq_error_event;

  always_comb begin
    next_seq_state = seq_state;
    next_first_value = first_value;
    next_mode_bit = mode_bit;
    seq_error_event = 1'b0;
    if (bus.store) begin
      case (seq_state)
        FSP_SEQ_IDLE: begin
          if (st_key) begin
            if (key_good) begin
              next_seq_state = FSP_SEQ_KEYED;
            end else begin
              seq_error_event = 1'b1;
            end
          end else if (st_mode) begin
            // unkeyed mode store is dropped
            seq_error_event = 1'b1;
          end
        end
        FSP_SEQ_KEYED: begin
          // a second key store is not a mode store and breaks the sequence
          if (st_mode) begin
            next_first_value = bus.wdata;
            next_seq_state = FSP_SEQ_FIRST;
          end else begin
            seq_error_event = 1'b1;
            next_seq_state = FSP_SEQ_IDLE;
          end
        end
        FSP_SEQ_FIRST: begin
          if (st_mode && (bus.wdata == ~first_value)) begin
            next_seq_state = FSP_SEQ_INVERTED;
          end else begin
            seq_error_event = 1'b1;
            next_seq_state = FSP_SEQ_IDLE;
          end
        end
        FSP_SEQ_INVERTED: begin
          if (st_mode && (bus.wdata == first_value)) begin
            // only bit 0 is kept; the whole byte was compared above
            next_mode_bit = bus.wdata[FSP_BIT_SELF_PROG];
          end else begin
            seq_error_event = 1'b1;
          end
          // every change needs a fresh key
          next_seq_state = FSP_SEQ_IDLE;
        end
        default: begin
          next_seq_state = FSP_SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_state <= FSP_SEQ_IDLE;
      first_value <= 8'h00;
      mode_bit <= FSP_RST_MODE;
    end else begin
      seq_state <= next_seq_state;
      first_value <= next_first_value;
      mode_bit <= next_mode_bit;
    end
  end

  // =====================================================================
  // command launch and result collection
  typedef enum logic [1:0] {
    FSP_EXE_IDLE,
    FSP_EXE_RUN,
    FSP_EXE_DONE
  } fsp_exe_e;

  fsp_exe_e exe_state;
  fsp_exe_e next_exe_state;
  logic [2:0] command;
  logic [2:0] next_command;
  logic next_array_start;
  logic [2:0] next_array_cmd;
  logic verify_event;
  logic protect_event;
  logic cmd_defined;
  logic exec_accept;

  // requests in normal mode are dropped, so a stray strobe never reaches the array
  assign exec_accept = exec_request && mode_bit;

  always_comb begin
    case (command)
      FSP_CMD_VERIFY1, FSP_CMD_VERIFY2, FSP_CMD_BLOCK_ERASE: cmd_defined = 1'b1;
      FSP_CMD_BLANK_CHECK, FSP_CMD_BYTE_WRITE: cmd_defined = 1'b1;
      default: cmd_defined = 1'b0;
    endcase
  end

  always_comb begin
    next_exe_state = exe_state;
    next_array_start = 1'b0;
    next_array_cmd = array_cmd;
    verify_event = 1'b0;
    protect_event = 1'b0;
    case (exe_state)
      FSP_EXE_IDLE: begin
        if (exec_accept) begin
          if (!cmd_defined) begin
            // undefined code ends at once with a verify failure
            verify_event = 1'b1;
            next_exe_state = FSP_EXE_DONE;
          end else if (block_protected) begin
            protect_event = 1'b1;
            next_exe_state = FSP_EXE_DONE;
          end else begin
            next_array_start = 1'b1;
            next_array_cmd = command;
            next_exe_state = FSP_EXE_RUN;
          end
        end
      end
      FSP_EXE_RUN: begin
        if (array_rsp.done) begin
          verify_event = array_rsp.verify_fail;
          protect_event = array_rsp.overwrite_zero;
          next_exe_state = FSP_EXE_DONE;
        end
      end
      FSP_EXE_DONE: begin
        // one settling cycle, so exec_done always follows a busy cycle
        next_exe_state = FSP_EXE_IDLE;
      end
      default: begin
        next_exe_state = FSP_EXE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exe_state <= FSP_EXE_IDLE;
      array_start <= 1'b0;
      array_cmd <= FSP_RST_COMMAND;
    end else begin
      exe_state <= next_exe_state;
      array_start <= next_array_start;
      array_cmd <= next_array_cmd;
    end
  end

  // =====================================================================
  // status flags: a hardware set always beats a software clear
  fsp_flags_s flags;
  fsp_flags_s next_flags;

  always_comb begin
    next_flags = flags;
    if (st_status) begin
      next_flags.sequence_error = flags.sequence_error & bus.wdata[FSP_BIT_SEQ_ERR];
      next_flags.verify_error = flags.verify_error & bus.wdata[FSP_BIT_VERIFY_ERR];
      next_flags.protect_error = flags.protect_error & bus.wdata[FSP_BIT_PROTECT_ERR];
    end
    // set events come after the clear, so a set in the same cycle wins
    if (seq_error_event) begin
      next_flags.sequence_error = 1'b1;
    end
    if (verify_event) begin
      next_flags.verify_error = 1'b1;
    end
    if (protect_event) begin
      next_flags.protect_error = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= FSP_RST_STATUS[2:0];
    end else begin
      flags <= next_flags;
    end
  end

  // =====================================================================
  // command select register, locked while a command runs
  logic cmd_write_ok;

  // a code written mid-command would only be seen by the next launch, so it is dropped
  assign cmd_write_ok = st_cmd && (exe_state == FSP_EXE_IDLE);

  always_comb begin
    next_command = command;
    if (cmd_write_ok) begin
      next_command = bus.wdata[FSP_CMD_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      command <= FSP_RST_COMMAND;
    end else begin
      command <= next_command;
    end
  end

  // =====================================================================
  // read port: one cycle after the load, unmapped and write-only read zero
  logic [7:0] next_rdata;
  logic [7:0] status_image;
  logic [7:0] mode_image;

  always_comb begin
    status_image = 8'h00;
    status_image[FSP_BIT_SEQ_ERR] = flags.sequence_error;
    status_image[FSP_BIT_VERIFY_ERR] = flags.verify_error;
    status_image[FSP_BIT_PROTECT_ERR] = flags.protect_error;
    mode_image = 8'h00;
    mode_image[FSP_BIT_SELF_PROG] = mode_bit;
    mode_image[FSP_PROT_LSB +: FSP_PROT_WIDTH] = protect_setting;
    next_rdata = 8'h00;
    if (bus.load) begin
      case (bus.addr)
        FSP_ADDR_ERROR_STATUS: next_rdata = status_image;
        FSP_ADDR_MODE_CONTROL: next_rdata = mode_image;
        FSP_ADDR_COMMAND_SELECT: next_rdata = {5'h00, command};
        // the key register is write-only, so the key never reads back
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // =====================================================================
  // registered outputs
  logic next_rvalid;
  logic next_exec_busy;
  logic next_exec_done;
  logic next_self_program_select;
  logic next_interrupt_hold;

  // every output leaves a flop so the core never sees decode glitches
  always_comb begin
    next_rvalid = bus.load;
    next_exec_busy = next_exe_state != FSP_EXE_IDLE;
    // early ends pass through the done state too, so one pulse covers every command
    next_exec_done = (exe_state != FSP_EXE_IDLE) && (next_exe_state == FSP_EXE_IDLE);
    next_self_program_select = next_mode_bit;
    // held off for the whole self-programming period
    next_interrupt_hold = next_mode_bit;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= FSP_RST_RDATA;
      rvalid <= 1'b0;
      exec_busy <= 1'b0;
      exec_done <= 1'b0;
      self_program_select <= FSP_RST_MODE;
      interrupt_hold <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      exec_busy <= next_exec_busy;
      exec_done <= next_exec_done;
      self_program_select <= next_self_program_select;
      interrupt_hold <= next_interrupt_hold;
    end
  end

endmodule

// [tb/fsp_protect_assertions.sv]
// checker: port timing and mode protection properties of the protect block
`timescale 1ns/10ps
module fsp_protect_assertions
  import fsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire fsp_bus_s bus,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic array_start,
  input wire logic [FSP_CMD_WIDTH-1:0] array_cmd,
  input wire logic exec_busy,
  input wire logic exec_done,
  input wire logic self_program_select,
  input wire logic interrupt_hold
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // =====================================================================
  // register bus
  a_read_answer: assert property (bus.load |=> rvalid) else $error("read not answered");
  a_read_cause: assert property (rvalid |-> $past(bus.load)) else $error("read answer without load");
  a_idle_rdata: assert property (!rvalid |-> rdata == 8'h00) else $error("read data not zero when idle");
  // =====================================================================
  // mode and interrupts
  a_irq_hold: assert property (interrupt_hold == self_program_select) else $error("interrupt hold off mode");
  a_mode_cause: assert property ($changed(self_program_select) |->
    $past(bus.store && bus.addr == FSP_ADDR_MODE_CONTROL)) else $error("mode changed without mode store");
  // =====================================================================
  // command launch
  a_launch_mode: assert property (array_start |-> self_program_select && exec_busy)
    else $error("launch outside self programming");
  a_start_pulse: assert property (array_start |=> !array_start) else $error("start longer than one cycle");
  a_done_end: assert property (exec_done |-> !exec_busy && $past(exec_busy))
    else $error("done without end of busy");
  a_cmd_hold: assert property (!array_start |-> $stable(array_cmd)) else $error("command changed without launch");
endmodule

bind fsp_protect fsp_protect_assertions u_chk (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .rvalid(rvalid),
  .array_start(array_start), .array_cmd(array_cmd), .exec_busy(exec_busy), .exec_done(exec_done),
  .self_program_select(self_program_select), .interrupt_hold(interrupt_hold));

// [tb/fsp_array_model.sv]
// flash array stand-in: answers each launch after a fixed delay
`timescale 1ns/10ps
module fsp_array_model
  import fsp_pkg::*;
#(
  parameter int DLY = 4
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic verify_fail,
  input wire logic overwrite_zero,
  output fsp_array_rsp_s rsp
);
  int cnt;
  // failure bits are shown only with done, never left standing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      rsp <= '0;
    end else begin
      rsp <= '0;
      if (start) begin
        cnt <= DLY;
      end else if (cnt == 1) begin
        cnt <= 0;
        rsp <= '{1'b1, verify_fail, overwrite_zero};
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// [tb/tb_top.sv]
// testbench: keyed mode unlock, status flags and command launch
`timescale 1ns/10ps
module tb_top;
  import fsp_pkg::*;
  localparam logic [4:0] PS = 5'h15;
  localparam logic [15:0] K = FSP_ADDR_PROTECT_KEY;
  localparam logic [15:0] S = FSP_ADDR_ERROR_STATUS;
  localparam logic [15:0] M = FSP_ADDR_MODE_CONTROL;
  localparam logic [15:0] C = FSP_ADDR_COMMAND_SELECT;
  logic clk, rst, exec_request, block_protected, vf, oz, rvalid, md;
  logic array_start, exec_busy, exec_done, self_program_select, interrupt_hold;
  logic [7:0] rdata;
  logic [2:0] array_cmd;
  fsp_bus_s bus;
  fsp_array_rsp_s rsp;
  int err_total, n_tests;
  fsp_protect u_dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .rvalid(rvalid), .protect_setting(PS),
    .block_protected(block_protected), .exec_request(exec_request), .array_rsp(rsp), .array_start(array_start),
    .array_cmd(array_cmd), .exec_busy(exec_busy), .exec_done(exec_done),
    .self_program_select(self_program_select), .interrupt_hold(interrupt_hold));
  fsp_array_model u_arr (.clk(clk), .rst(rst), .start(array_start), .verify_fail(vf), .overwrite_zero(oz),
    .rsp(rsp));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // =====================================================================
  // shared tasks
  task automatic test_done();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // op and st never release the bus, so back-to-back stores keep one assignment per step
  task automatic op(input logic s, input logic l, input logic [15:0] a, input logic [7:0] d);
    bus = '{s, l, a, d};
    @(posedge clk);
    #1;
  endtask
  task automatic st(input logic [15:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input string n, input logic [15:0] a, input logic [7:0] e);
    op(1'b0, 1'b1, a, 8'h00);
    chk("rvalid", 8'h01, {7'h00, rvalid});
    chk(n, e, rdata);
    op(1'b0, 1'b0, 16'h0000, 8'h00);
  endtask
  task automatic pin();
    chk("select", {7'h00, md}, {7'h00, self_program_select});
    chk("hold", {7'h00, md}, {7'h00, interrupt_hold});
  endtask
  task automatic cm();
    pin();
    rd("mode", M, {1'b0, PS, 1'b0, md});
  endtask
  task automatic try(input logic [7:0] k, input logic [15:0] a, input logic [7:0] d1, d2, d3,
                     input logic nm, input logic [7:0] es);
    st(K, k);
    st(a, d1);
    st(M, d2);
    pin();
    st(M, d3);
    op(1'b0, 1'b0, 16'h0000, 8'h00);
    md = nm;
    cm();
    rd("status", S, es);
    st(S, 8'h00);
  endtask
  task automatic run(input logic [2:0] cmd, input logic v, o, p, input logic [7:0] es);
    int i;
    logic go;
    go = !p && (cmd inside {[1:5]});
    st(C, {5'h00, cmd});
    rd("command", C, {5'h00, cmd});
    vf = v;
    oz = o;
    block_protected = p;
    exec_request = 1'b1;
    op(1'b0, 1'b0, 16'h0000, 8'h00);
    exec_request = 1'b0;
    chk("busy", 8'h01, {7'h00, exec_busy});
    chk("start", {7'h00, go}, {7'h00, array_start});
    for (i = 0; i < 100 && exec_done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (exec_done !== 1'b1) begin
      err_total++;
      test_done();
    end
    if (go) begin
      chk("array cmd", {5'h00, cmd}, {5'h00, array_cmd});
    end
    rd("status", S, es);
    st(S, 8'h00);
  endtask
  // =====================================================================
  // scenarios
  task automatic t_reset();
    rst = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    md = 1'b0;
    rd("status", S, 8'h00);
    rd("command", C, 8'h00);
    cm();
    rd("key", K, 8'h00);
    rd("unmapped", 16'hFF00, 8'h00);
  endtask
  task automatic t_relock();
    st(M, 8'h00);
    op(1'b0, 1'b0, 16'h0000, 8'h00);
    cm();
    rd("status", S, 8'h01);
    st(S, 8'h07);
    rd("status", S, 8'h01);
    st(S, 8'hFE);
    rd("status", S, 8'h00);
  endtask
  task automatic t_seq_err();
    try(8'hA5, M, 8'h00, 8'h00, 8'h00, 1'b1, 8'h01);
    try(8'hA5, M, 8'h00, 8'hFF, 8'h01, 1'b1, 8'h01);
    try(8'hA5, C, 8'h00, 8'hFF, 8'h00, 1'b1, 8'h01);
    try(8'h5A, M, 8'h00, 8'hFF, 8'h00, 1'b1, 8'h01);
  endtask
  task automatic t_cmds();
    run(3'h1, 1'b0, 1'b0, 1'b0, 8'h00);
    run(3'h1, 1'b1, 1'b0, 1'b0, 8'h02);
    run(3'h2, 1'b0, 1'b1, 1'b0, 8'h04);
    run(3'h3, 1'b0, 1'b0, 1'b0, 8'h00);
    run(3'h3, 1'b0, 1'b0, 1'b1, 8'h04);
    run(3'h0, 1'b0, 1'b0, 1'b0, 8'h02);
    run(3'h7, 1'b0, 1'b0, 1'b0, 8'h02);
    run(3'h4, 1'b1, 1'b0, 1'b0, 8'h02);
    run(3'h5, 1'b0, 1'b1, 1'b0, 8'h04);
  endtask
  task automatic t_no_exec();
    st(C, {5'h00, FSP_CMD_BLOCK_ERASE});
    exec_request = 1'b1;
    op(1'b0, 1'b0, 16'h0000, 8'h00);
    exec_request = 1'b0;
    chk("busy", 8'h00, {7'h00, exec_busy});
    chk("start", 8'h00, {7'h00, array_start});
    op(1'b0, 1'b0, 16'h0000, 8'h00);
    chk("done", 8'h00, {7'h00, exec_done});
  endtask
  initial begin
    rst = 1'b1;
    bus = '0;
    exec_request = 1'b0;
    block_protected = 1'b0;
    vf = 1'b0;
    oz = 1'b0;
    md = 1'b0;
    err_total = 0;
    n_tests = 0;
    t_reset();
    try(8'hA5, M, 8'h01, 8'hFE, 8'h01, 1'b1, 8'h00);
    t_relock();
    t_seq_err();
    t_cmds();
    try(8'hA5, M, 8'h00, 8'hFF, 8'h00, 1'b0, 8'h00);
    t_no_exec();
    st(M, 8'h01);
    t_reset();
    test_done();
  end
endmodule
